// ---- pcip_input_cond.sv ----
// sequence clock selection, input gating and polarity conditioning
// Notes on behaviour
// - toggle sequence clock source, show active source
// - preset selects the internal sequence clock
// - external clock divided by 1,2,4,8; preset 1
// - internal rates 10/5/2.5/1.25 MHz; preset 10
// - rate and divide ratio are independent settings
// - internal clock ignores all data and clocks
// - external, no framing: only in-phase clock used
// - external with framing: quadrature bit0 is frame
// - per-bit data inversion, reselecting clears it
// - one toggled polarity flag per clock-type input
// - serial inversion complements whole stream only
// - preset clears every inversion flag
// - latch data on in-phase clock active edge; qClkSep latches quadrature data on its own clock
// - frame active edge moves shift word out
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "pcip_defs.svh"
module pcip_input_cond (
  input  wire logic               core_clk,       // 20 MHz system clock
  input  wire logic               reset_n,        // async reset, active low
  input  pcip_pkg::pcip_axi_req_t axiReq,         // register bus requests
  output pcip_pkg::pcip_axi_rsp_t axiRsp,         // register bus answers
  input  wire logic [3:0]         iDataPin,       // in-phase data bits 0..3
  input  wire logic [3:0]         qDataPin,       // quadrature data bits 0..3
  input  wire logic               iClkPin,        // in-phase clock input
  input  wire logic               qClkPin,        // quadrature clock input
  input  wire logic               burstPin,       // burst input
  output logic [3:0]              iDataOut,       // in-phase word to modulator
  output logic [3:0]              qDataOut,       // quadrature word to modulator
  output logic                    burstOut,       // conditioned burst level
  output logic                    seqClkTick,     // sequence generator clock pulse
  output logic                    seqFrameTick,   // external frame pulse
  output logic                    seqClkExtActive // external source indicator
);
  import pcip_pkg::*;

  pcip_ctrl_t  ctrl_r;
  pcip_inv_t   inv_r;
  logic [3:0]  iDataOut_r;
  logic [3:0]  qDataOut_r;
  logic        burstOut_r;
  logic        seqFrameTick_r;
  logic [3:0]  shReg_r;
  logic [1:0]  bitCnt_r;
  logic [4:0]  edgePrev_r;
  logic        wrGo;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic [31:0] rdAddr;
  logic [31:0] rdData;
  logic [31:0] wMask;
  pcip_reg_t   wrSel;
  pcip_reg_t   rdSel;
  logic        useParI;
  logic        useSer;
  logic        useSeqExt;
  logic        useSeqInt;
  logic        useFrame;
  logic [3:0]  iDataC;
  logic [3:0]  qDataC;
  logic [4:0]  edgeNow;
  logic        iClkEdge;
  logic        qClkEdge;
  logic        seqEdge;
  logic        serEdge;
  logic        frameEdge;
  logic        serDataC;
  logic        serXfer;
  logic [3:0]  serWord;
  logic        divEvt;
  logic [`PCIP_EXP_W-1:0] divExp;
  pcip_stat_t  stat;
  pcip_ctrl_t  wrCtrl;

  function automatic pcip_reg_t regSel(input logic [31:0] addr);
    logic [31:0] a;
    a = {addr[31:2], 2'b00};
    if (a == `PCIP_OFS_CTRL) return REG_CTRL;
    else if (a == `PCIP_OFS_INV) return REG_INV;
    else if (a == `PCIP_OFS_STAT) return REG_STAT;
    else if (a == `PCIP_OFS_KEY) return REG_KEY;
    else return REG_NONE;
  endfunction

  function automatic logic [31:0] strbMask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  pcip_axil_slave u_bus (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .axiReq   (axiReq),
    .axiRsp   (axiRsp),
    .wrGo     (wrGo),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .wrStrb   (wrStrb),
    .wrOk     (wrSel != REG_NONE),
    .rdAddr   (rdAddr),
    .rdData   (rdData),
    .rdOk     (rdSel != REG_NONE)
  );

  assign wrSel = regSel(wrAddr);
  assign rdSel = regSel(rdAddr);
  assign wMask = strbMask(wrStrb);
  assign wrCtrl = pcip_ctrl_t'(wrData[`PCIP_CTRL_W-1:0]);

  // control: plain write, or write-one-to-toggle through the key register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `PCIP_CTRL_RST;
    end else if (wrGo && wrSel == REG_CTRL) begin
      ctrl_r <= pcip_ctrl_t'(`PCIP_CTRL_W'((ctrl_r & ~wMask) | (wrData & wMask)));
    end else if (wrGo && wrSel == REG_KEY && wrStrb[0]) begin
      ctrl_r.seqExt   <= ctrl_r.seqExt ^ wrData[`PCIP_KEY_SRC];
      ctrl_r.frameExt <= ctrl_r.frameExt ^ wrData[`PCIP_KEY_FRAME];
    end
  end

  // inversion flags toggle on every written one
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      inv_r <= `PCIP_INV_RST;
    end else if (wrGo && wrSel == REG_INV) begin
      inv_r <= pcip_inv_t'(`PCIP_INV_W'(inv_r ^ (wrData & wMask)));
    end
  end

  always_comb begin
    stat          = '0;
    stat.qData    = qDataOut_r;
    stat.iData    = iDataOut_r;
    stat.burst    = burstOut_r;
    stat.frameExt = useFrame;
    stat.seqExt   = ctrl_r.seqExt;
  end

  always_comb begin
    rdData = '0;
    unique case (rdSel)
      REG_CTRL: rdData = 32'(ctrl_r);
      REG_INV:  rdData = 32'(inv_r);
      REG_STAT: rdData = 32'(stat);
      REG_KEY:  rdData = '0;
      REG_NONE: rdData = '0;
    endcase
  end

  // which inputs take part in the current mode
  always_comb begin
    useParI   = !ctrl_r.prbsEn && !ctrl_r.serialMode;
    useSer    = !ctrl_r.prbsEn && ctrl_r.serialMode;
    useSeqExt = ctrl_r.prbsEn && ctrl_r.seqExt;
    useSeqInt = ctrl_r.prbsEn && !ctrl_r.seqExt;
    useFrame  = ctrl_r.frameExt && (useSer || useSeqExt);
  end

  // polarity first, then edge detection on the conditioned level
  assign iDataC   = iDataPin ^ inv_r.iBits;
  assign qDataC   = qDataPin ^ inv_r.qBits;
  assign serDataC = iDataPin[0] ^ inv_r.serData;
  assign edgeNow  = {qDataPin[0] ^ inv_r.frame, iClkPin ^ inv_r.serClk,
                     iClkPin ^ inv_r.seqClk, qClkPin ^ inv_r.qClk,
                     iClkPin ^ inv_r.iClk};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      edgePrev_r <= '0;
    end else begin
      edgePrev_r <= edgeNow;
    end
  end

  assign iClkEdge  = useParI && edgeNow[0] && !edgePrev_r[0];
  assign qClkEdge  = useParI && ctrl_r.qClkSep && edgeNow[1] && !edgePrev_r[1];
  assign seqEdge   = useSeqExt && edgeNow[2] && !edgePrev_r[2];
  assign serEdge   = useSer && edgeNow[3] && !edgePrev_r[3];
  assign frameEdge = useFrame && edgeNow[4] && !edgePrev_r[4];

  // one divider serves both sources; rate and ratio stay separate fields
  assign divEvt = useSeqExt ? seqEdge : useSeqInt;
  assign divExp = ctrl_r.seqExt ? `PCIP_EXP_W'(ctrl_r.extDiv)
                : `PCIP_EXP_W'(ctrl_r.intRate) + `PCIP_EXP_W'(`PCIP_INT_BASE_EXP);

  pcip_pulse_div u_div (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .evt      (divEvt),
    .ratioExp (divExp),
    .pulse    (seqClkTick)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seqFrameTick_r <= 1'b0;
    end else begin
      seqFrameTick_r <= frameEdge && useSeqExt;
    end
  end

  // serial stream shift register, one bit per serial clock edge
  assign serWord = {shReg_r[`PCIP_SER_BITS-2:0], serDataC};
  assign serXfer = ctrl_r.frameExt ? frameEdge
                 : (serEdge && bitCnt_r == `PCIP_SER_LAST);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shReg_r  <= '0;
      bitCnt_r <= '0;
    end else if (serEdge) begin
      shReg_r  <= serWord;
      bitCnt_r <= bitCnt_r + 1'b1;
    end
  end

  // internal framing hands over the word that the current edge completes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      iDataOut_r <= '0;
    end else if (iClkEdge) begin
      iDataOut_r <= iDataC;
    end else if (useSer && serXfer) begin
      iDataOut_r <= ctrl_r.frameExt ? shReg_r : serWord;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      qDataOut_r <= '0;
    end else if (ctrl_r.qClkSep ? qClkEdge : iClkEdge) begin
      qDataOut_r <= qDataC;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      burstOut_r <= 1'b0;
    end else begin
      burstOut_r <= burstPin ^ inv_r.burst;
    end
  end

  assign iDataOut        = iDataOut_r;
  assign qDataOut        = qDataOut_r;
  assign burstOut        = burstOut_r;
  assign seqFrameTick    = seqFrameTick_r;
  assign seqClkExtActive = ctrl_r.seqExt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic quiet;
  assign quiet = !wrGo;

  AST_SRC_TOGGLE: assert property (
    wrGo && wrSel == REG_KEY && wrStrb[0] && wrData[`PCIP_KEY_SRC]
    |=> seqClkExtActive != $past(seqClkExtActive))
    else $error("source key did not toggle the source indicator");

  AST_PRESET: assert property (
    $rose(reset_n) |-> !seqClkExtActive && ctrl_r.extDiv == '0 && ctrl_r.intRate == '0)
    else $error("preset did not select internal clock at fastest rate");

  AST_PRESET_INV: assert property (
    $rose(reset_n) |-> inv_r == '0 && !burstOut)
    else $error("preset left an inversion flag set");

  AST_EXT_DIV1: assert property (
    seqEdge && ctrl_r.extDiv == '0 |=> seqClkTick)
    else $error("divide by one missed an external edge");

  AST_INT_FAST: assert property (
    seqClkTick && useSeqInt && ctrl_r.intRate == '0 && quiet ##1 quiet
    |=> !$past(seqClkTick) && seqClkTick)
    else $error("internal fastest rate is not every second cycle");

  AST_RATE_KEEPS_DIV: assert property (
    wrGo && wrSel == REG_CTRL && wrStrb[0]
    |=> ctrl_r.extDiv == $past(wrCtrl.extDiv) && ctrl_r.intRate[0] == $past(wrCtrl.intRate[0]))
    else $error("control write mixed up the divide ratio and the rate");

  AST_INT_IGNORES: assert property (
    useSeqInt |=> $stable(iDataOut) && $stable(qDataOut) && !seqFrameTick)
    else $error("data changed while the internal clock runs");

  AST_EXT_NOFRAME: assert property (
    useSeqExt && !ctrl_r.frameExt |=> $stable(qDataOut) && !seqFrameTick)
    else $error("framing-off external mode used an ignored input");

  AST_EXT_FRAME: assert property (
    useSeqExt && ctrl_r.frameExt && frameEdge |=> seqFrameTick)
    else $error("frame edge on quadrature bit zero was not passed on");

  AST_INV_TOGGLE: assert property (
    wrGo && wrSel == REG_INV && wrStrb == 4'hF
    |=> inv_r == ($past(inv_r) ^ pcip_inv_t'($past(wrData[`PCIP_INV_W-1:0]))))
    else $error("inversion write did not toggle the flags");

  AST_SER_INVERT: assert property (
    serEdge |=> shReg_r[0] == $past(iDataPin[0] ^ inv_r.serData))
    else $error("serial bit not taken with its polarity");

  AST_PAR_LATCH: assert property (
    iClkEdge |=> iDataOut == $past(iDataPin ^ inv_r.iBits))
    else $error("parallel word not latched on the active clock edge");

  AST_FRAME_XFER: assert property (
    useSer && ctrl_r.frameExt && frameEdge |=> iDataOut == $past(shReg_r))
    else $error("frame edge did not move the shift word out");

  // mode gating and polarity of the remaining inputs
  AST_QSEP_LATCH: assert property (
    qClkEdge |=> qDataOut == $past(qDataPin ^ inv_r.qBits))
    else $error("quadrature word not latched on its own clock edge");

  AST_BURST_POL: assert property (
    1'b1 |=> burstOut == $past(burstPin ^ inv_r.burst))
    else $error("burst level not passed with its polarity");

  AST_FRAME_SEQ_ONLY: assert property (
    !useSeqExt |=> !seqFrameTick)
    else $error("frame pulse outside external sequence mode");

  AST_EXT_TICK: assert property (
    useSeqExt && !seqEdge |=> !seqClkTick)
    else $error("external sequence tick without an in-phase clock edge");

  AST_SER_INT_XFER: assert property (
    useSer && !ctrl_r.frameExt && serEdge && bitCnt_r == `PCIP_SER_LAST
    |=> iDataOut == $past({shReg_r[`PCIP_SER_BITS-2:0], serDataC}))
    else $error("internal framing did not hand over the completed word");

  COV_INT_TICK: cover property (useSeqInt && seqClkTick);
  COV_QSEP_EDGE: cover property (qClkEdge);
  COV_EXT_TICK: cover property (useSeqExt && ctrl_r.extDiv == 2'h3 && seqClkTick);
  COV_FRAME: cover property (seqFrameTick);
  COV_SER_XFER: cover property (useSer && serXfer);
endmodule

// ---- pcip_defs.svh ----
// timing, offsets, reset values and encodings for the input conditioning block
`ifndef PCIP_DEFS_SVH
`define PCIP_DEFS_SVH
`define PCIP_CLK_MHZ       20
`define PCIP_INT_FAST_MHZ  10
`define PCIP_INT_BASE_EXP  ($clog2(`PCIP_CLK_MHZ / `PCIP_INT_FAST_MHZ))
`define PCIP_EXP_W         3
`define PCIP_CNT_W         4
`define PCIP_OFS_CTRL      32'h0000_0000
`define PCIP_OFS_INV       32'h0000_0004
`define PCIP_OFS_STAT      32'h0000_0008
`define PCIP_OFS_KEY       32'h0000_000C
`define PCIP_CTRL_W        9
`define PCIP_INV_W         15
`define PCIP_STAT_W        11
`define PCIP_CTRL_RST      9'h000
`define PCIP_INV_RST       15'h0000
`define PCIP_KEY_SRC       0
`define PCIP_KEY_FRAME     1
`define PCIP_SER_BITS      4
`define PCIP_SER_LAST      2'h3
`define PCIP_RESP_OKAY     2'h0
`define PCIP_RESP_DECERR   2'h3
`endif

// ---- pcip_pkg.sv ----
// types shared by the input conditioning block
package pcip_pkg;
  `include "pcip_defs.svh"

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } pcip_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcip_axi_rsp_t;

  typedef struct packed {
    logic [1:0] intRate;
    logic [1:0] extDiv;
    logic       qClkSep;
    logic       serialMode;
    logic       prbsEn;
    logic       frameExt;
    logic       seqExt;
  } pcip_ctrl_t;

  typedef struct packed {
    logic       seqClk;
    logic       serClk;
    logic       serData;
    logic       burst;
    logic       frame;
    logic       qClk;
    logic       iClk;
    logic [3:0] qBits;
    logic [3:0] iBits;
  } pcip_inv_t;

  typedef struct packed {
    logic [3:0] qData;
    logic [3:0] iData;
    logic       burst;
    logic       frameExt;
    logic       seqExt;
  } pcip_stat_t;

  typedef enum logic [2:0] {REG_CTRL, REG_INV, REG_STAT, REG_KEY, REG_NONE} pcip_reg_t;
endpackage

// ---- pcip_pulse_div.sv ----
// divides a stream of one-cycle events by a power of two
`timescale 1ns/100ps
`include "pcip_defs.svh"
module pcip_pulse_div (
  input  wire logic                  core_clk,  // system clock
  input  wire logic                  reset_n,   // async reset, active low
  input  wire logic                  evt,       // one-cycle event to count
  input  wire logic [`PCIP_EXP_W-1:0] ratioExp, // divide by two to this power
  output logic                       pulse      // one pulse per ratio events
);
  import pcip_pkg::*;

  logic [`PCIP_CNT_W-1:0] cnt_r;
  logic [`PCIP_CNT_W-1:0] cntMax;
  logic                   pulse_r;

  assign cntMax = `PCIP_CNT_W'(({1'b0, `PCIP_CNT_W'(1)} << ratioExp) - 1'b1);

  // a shrinking ratio may leave the count above the limit, so wrap on >=
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (evt) begin
      cnt_r <= (cnt_r >= cntMax) ? '0 : cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= evt && (cnt_r >= cntMax);
    end
  end

  assign pulse = pulse_r;
endmodule

// ---- pcip_axil_slave.sv ----
// AXI4-Lite slave front end, one write and one read under way at a time
`timescale 1ns/100ps
`include "pcip_defs.svh"
module pcip_axil_slave (
  input  wire logic                   core_clk, // system clock
  input  wire logic                   reset_n,  // async reset, active low
  input  pcip_pkg::pcip_axi_req_t     axiReq,   // master to slave channels
  output pcip_pkg::pcip_axi_rsp_t     axiRsp,   // slave to master channels
  output logic                        wrGo,     // one-cycle register write
  output logic [31:0]                 wrAddr,   // write byte address
  output logic [31:0]                 wrData,   // write data
  output logic [3:0]                  wrStrb,   // write byte enables
  input  wire logic                   wrOk,     // write address is mapped
  output logic [31:0]                 rdAddr,   // read byte address
  input  wire logic [31:0]            rdData,   // read data for rdAddr
  input  wire logic                   rdOk      // read address is mapped
);
  import pcip_pkg::*;

  logic        awHeld_r;
  logic [31:0] awAddr_r;
  logic        wHeld_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;
  logic        rValid_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;
  logic        awTake;
  logic        wTake;
  logic        arTake;

  assign awTake = axiReq.awvalid && !awHeld_r && !bValid_r;
  assign wTake  = axiReq.wvalid && !wHeld_r && !bValid_r;
  assign arTake = axiReq.arvalid && !rValid_r;
  assign wrGo   = awHeld_r && wHeld_r && !bValid_r;
  assign wrAddr = awAddr_r;
  assign wrData = wData_r;
  assign wrStrb = wStrb_r;
  assign rdAddr = axiReq.araddr;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (awTake) begin
      awHeld_r <= 1'b1;
      awAddr_r <= axiReq.awaddr;
    end else if (wrGo) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (wTake) begin
      wHeld_r <= 1'b1;
      wData_r <= axiReq.wdata;
      wStrb_r <= axiReq.wstrb;
    end else if (wrGo) begin
      wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bValid_r <= 1'b0;
      bResp_r  <= `PCIP_RESP_OKAY;
    end else if (wrGo) begin
      bValid_r <= 1'b1;
      bResp_r  <= wrOk ? `PCIP_RESP_OKAY : `PCIP_RESP_DECERR;
    end else if (axiReq.bready) begin
      bValid_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rValid_r <= 1'b0;
      rData_r  <= '0;
      rResp_r  <= `PCIP_RESP_OKAY;
    end else if (arTake) begin
      rValid_r <= 1'b1;
      rData_r  <= rdData;
      rResp_r  <= rdOk ? `PCIP_RESP_OKAY : `PCIP_RESP_DECERR;
    end else if (axiReq.rready) begin
      rValid_r <= 1'b0;
    end
  end

  always_comb begin
    axiRsp         = '0;
    axiRsp.awready = !awHeld_r && !bValid_r;
    axiRsp.wready  = !wHeld_r && !bValid_r;
    axiRsp.bvalid  = bValid_r;
    axiRsp.bresp   = bResp_r;
    axiRsp.arready = !rValid_r;
    axiRsp.rvalid  = rValid_r;
    axiRsp.rdata   = rData_r;
    axiRsp.rresp   = rResp_r;
  end
endmodule

// ---- pcip_src_model.sv ----
// external data and clock source model for the conditioning block pins
`timescale 1ns/100ps
module pcip_src_model (
  input  wire logic  core_clk, // system clock
  input  wire logic  burstLvl, // burst level to present
  output logic [3:0] iDataPin, // in-phase data pins
  output logic [3:0] qDataPin, // quadrature data pins
  output logic       iClkPin,  // in-phase clock pin
  output logic       qClkPin,  // quadrature clock pin
  output logic       burstPin  // burst pin
);
  initial begin
    iDataPin = 4'h0;
    qDataPin = 4'h0;
    iClkPin = 1'b0;
    qClkPin = 1'b0;
  end
  always @(posedge core_clk) burstPin <= burstLvl;
  task automatic waitN(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // rising clock edge sees d, falling edge sees ~d
  task automatic parWord(input logic [3:0] di, input logic [3:0] dq);
    iDataPin <= di;
    qDataPin <= dq;
    waitN(2);
    iClkPin <= 1'b1;
    qClkPin <= 1'b1;
    waitN(2);
    iDataPin <= ~di;
    qDataPin <= ~dq;
    waitN(2);
    iClkPin <= 1'b0;
    qClkPin <= 1'b0;
    waitN(2);
  endtask
  task automatic clkPulse(input int n);
    repeat (n) begin
      iClkPin <= 1'b1;
      waitN(2);
      iClkPin <= 1'b0;
      waitN(2);
    end
  endtask
  // msb first on the serial line
  task automatic serWord(input logic [3:0] w);
    for (int b = 3; b >= 0; b--) begin
      iDataPin[0] <= w[b];
      waitN(2);
      clkPulse(1);
    end
  endtask
  task automatic frame();
    qDataPin <= 4'h0;
    waitN(2);
    qDataPin[0] <= 1'b1;
    waitN(2);
    qDataPin[0] <= 1'b0;
    waitN(2);
  endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the input conditioning block
`timescale 1ns/100ps
`include "pcip_defs.svh"
module testbench;
  import pcip_pkg::*;
  logic          core_clk, reset_n, burstLvl;
  pcip_axi_req_t axiReq;
  pcip_axi_rsp_t axiRsp;
  logic [3:0]    iDataPin, qDataPin, iDataOut, qDataOut, w;
  logic          iClkPin, qClkPin, burstPin, burstOut;
  logic          seqClkTick, seqFrameTick, seqClkExtActive;
  logic [31:0]   rdV;
  logic [1:0]    rsp;
  logic [14:0]   invS;
  int            n_errors = 0, n_compared = 0, nTick = 0, nFrame = 0, cycles = 0, t0;

  pcip_input_cond uut (.core_clk, .reset_n, .axiReq, .axiRsp, .iDataPin, .qDataPin, .iClkPin,
    .qClkPin, .burstPin, .iDataOut, .qDataOut, .burstOut, .seqClkTick, .seqFrameTick,
    .seqClkExtActive);
  pcip_src_model src (.core_clk, .burstLvl, .iDataPin, .qDataPin, .iClkPin, .qClkPin,
    .burstPin);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (seqClkTick === 1'b1) nTick <= nTick + 1;
    if (seqFrameTick === 1'b1) nFrame <= nFrame + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // latched word: inverted clock takes the falling-edge data
  function automatic logic [3:0] latchVal(input logic [3:0] d, input logic ck,
                                          input logic [3:0] inv);
    return (ck ? ~d : d) ^ inv;
  endfunction

  task automatic axWr(input logic [31:0] a, input logic [31:0] d);
    logic aw, wd, b;
    @(posedge core_clk);
    aw = 1'b1;
    wd = 1'b1;
    b = 1'b1;
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    while (aw || wd || b) begin
      @(negedge core_clk);
      if (axiRsp.awready === 1'b1) aw = 1'b0;
      if (axiRsp.wready === 1'b1) wd = 1'b0;
      if (axiRsp.bvalid === 1'b1) begin
        b = 1'b0;
        rsp = axiRsp.bresp;
      end
      @(posedge core_clk);
      axiReq.awvalid <= aw;
      axiReq.wvalid <= wd;
      axiReq.bready <= b;
    end
  endtask

  task automatic axRd(input logic [31:0] a);
    logic ar, r;
    @(posedge core_clk);
    ar = 1'b1;
    r = 1'b1;
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    while (ar || r) begin
      @(negedge core_clk);
      if (axiRsp.arready === 1'b1) ar = 1'b0;
      if (axiRsp.rvalid === 1'b1) begin
        r = 1'b0;
        rdV = axiRsp.rdata;
        rsp = axiRsp.rresp;
      end
      @(posedge core_clk);
      axiReq.arvalid <= ar;
      axiReq.rready <= r;
    end
  endtask

  task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
    axRd(a);
    check(rdV, e);
    check(32'(rsp), 32'(`PCIP_RESP_OKAY));
  endtask

  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask

  initial begin
    axiReq = '0;
    burstLvl = 1'b0;
    reset_n = 1'b0;
    void'($urandom(32'h6E1B));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rdChk(`PCIP_OFS_CTRL, 32'h0);
    rdChk(`PCIP_OFS_INV, 32'h0);
    check(32'(seqClkExtActive), 32'h0);
    axRd(32'h0000_0010);
    check(32'(rsp), 32'(`PCIP_RESP_DECERR));
    check(rdV, 32'h0);
    axWr(32'h0000_0010, 32'hFFFF_FFFF);
    check(32'(rsp), 32'(`PCIP_RESP_DECERR));
    // internal rates: one tick every 2, 4, 8, 16 cycles
    for (int r = 0; r < 4; r++) begin
      axWr(`PCIP_OFS_CTRL, 32'((r << 7) | 4));
      repeat (32) @(posedge core_clk);
      t0 = nTick;
      repeat (64) @(posedge core_clk);
      check(32'(nTick - t0), 32'(64 >> (r + 1)));
    end
    w = 4'($urandom);
    src.parWord(w, ~w);
    settle();
    check(32'({iDataOut, qDataOut}), 32'h0);
    axWr(`PCIP_OFS_CTRL, 32'h0000_01A4);
    check(32'(rsp), 32'(`PCIP_RESP_OKAY));
    axWr(`PCIP_OFS_KEY, 32'h0000_0002);
    rdChk(`PCIP_OFS_CTRL, 32'h0000_01A6);
    // external sequence clock, divider cleared by a fresh reset
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    axWr(`PCIP_OFS_KEY, 32'h0000_0001);
    settle();
    check(32'(seqClkExtActive), 32'h1);
    rdChk(`PCIP_OFS_STAT, 32'h1);
    for (int d = 0; d < 4; d++) begin
      axWr(`PCIP_OFS_CTRL, 32'((d << 5) | 5));
      t0 = nTick;
      src.clkPulse(16);
      repeat (4) @(posedge core_clk);
      check(32'(nTick - t0), 32'(16 >> d));
    end
    axWr(`PCIP_OFS_CTRL, 32'h5);
    axWr(`PCIP_OFS_INV, 32'h4000);
    repeat (4) @(posedge core_clk);
    t0 = nTick;
    src.clkPulse(16);
    repeat (4) @(posedge core_clk);
    check(32'(nTick - t0), 32'd16);
    axWr(`PCIP_OFS_INV, 32'h4000);
    t0 = nFrame;
    src.frame();
    src.parWord(4'hA, 4'h5);
    settle();
    check(32'(nFrame - t0), 32'h0);
    check(32'({iDataOut, qDataOut}), 32'h0);
    axWr(`PCIP_OFS_CTRL, 32'h7);
    t0 = nFrame;
    src.frame();
    check(32'(nFrame - t0), 32'h1);
    rdChk(`PCIP_OFS_STAT, 32'h3);
    // parallel latching with random inversions
    axWr(`PCIP_OFS_CTRL, 32'h0);
    settle();
    check(32'(seqClkExtActive), 32'h0);
    invS = '0;
    for (int k = 0; k < 8; k++) begin
      rdV = (k < 2) ? 32'h1FF : ($urandom & 32'h9FF);
      axWr(`PCIP_OFS_INV, rdV);
      invS ^= rdV[14:0];
      rdChk(`PCIP_OFS_INV, 32'(invS));
      burstLvl <= 1'($urandom);
      w = 4'($urandom);
      src.parWord(w, ~w);
      settle();
      check(32'(iDataOut), 32'(latchVal(w, invS[8], invS[3:0])));
      check(32'(qDataOut), 32'(latchVal(~w, invS[8], invS[7:4])));
      check(32'(burstOut), 32'(burstLvl ^ invS[11]));
    end
    // separate quadrature clock, inverted against the in-phase clock
    axWr(`PCIP_OFS_CTRL, 32'h0000_0010);
    axWr(`PCIP_OFS_INV, 32'h0000_0200);
    invS ^= 15'h0200;
    w = 4'($urandom);
    src.parWord(w, ~w);
    settle();
    check(32'(iDataOut), 32'(latchVal(w, invS[8], invS[3:0])));
    check(32'(qDataOut), 32'(latchVal(~w, invS[9], invS[7:4])));
    // serial words framed externally, then internally
    axWr(`PCIP_OFS_INV, 32'(invS));
    axWr(`PCIP_OFS_CTRL, 32'h0000_000A);
    for (int k = 0; k < 3; k++) begin
      if (k == 1) axWr(`PCIP_OFS_INV, 32'h1000);
      if (k == 2) axWr(`PCIP_OFS_CTRL, 32'h0000_0008);
      w = 4'($urandom);
      src.serWord(w);
      src.frame();
      settle();
      check(32'(iDataOut), 32'(w ^ {4{k != 0}}));
    end
    end_of_test();
  end
endmodule
